// >>> chan_cfg_decode.sv
`timescale 1ns/1ps
`default_nettype none

// Registers the decoded analog settings of one channel.
module chan_cfg_decode (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire redriver_pkg::chan_pins_type pins,
  output redriver_pkg::chan_cfg_type cfg
);

  wire redriver_pkg::chan_cfg_type next_cfg;

  assign next_cfg.boost = redriver_pkg::decode_level(pins.boost_sel_hi,
                                                     pins.boost_sel_lo);
  assign next_cfg.deemph = redriver_pkg::decode_level(pins.deemph_sel_hi,
                                                      pins.deemph_sel_lo);
  // swing level from the select bit.
  assign next_cfg.swing = pins.swing_sel ? redriver_pkg::swing_750mv
                                         : redriver_pkg::swing_1000mv;

  // Reset gives the lowest settings, as undriven pins do.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg <= '0;
    end else if (ce) begin
      cfg <= next_cfg;
    end
  end

endmodule

`default_nettype wire

// >>> lane_control_properties.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Port relations of the lane control
// ****************************************************************

// Watches the top ports; all checks share one clock and reset.
module lane_control_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic enable,
  input wire logic [1:0] above_idle_threshold,
  input wire redriver_pkg::chan_pins_type pins_a,
  input wire redriver_pkg::chan_pins_type pins_b,
  input wire redriver_pkg::chan_cfg_type cfg_a,
  input wire redriver_pkg::chan_cfg_type cfg_b,
  input wire logic [1:0] probe_active,
  input wire logic standby,
  input wire logic [1:0] driver_en,
  input wire logic [1:0] idle_detect_en,
  input wire logic [1:0] out_active,
  input wire logic [1:0] detected
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  boost_decode_a: assert property ((ce && $stable(pins_a))[*8] |->
    cfg_a.boost == (pins_a.boost_sel_hi ? 2'h2 : {1'b0, pins_a.boost_sel_lo}))
    else $error("boost setting of channel A wrong");
  deemph_decode_a: assert property ((ce && $stable(pins_b))[*8] |->
    cfg_b.deemph == (pins_b.deemph_sel_hi ? 2'h2 :
    {1'b0, pins_b.deemph_sel_lo}))
    else $error("de-emphasis setting of channel B wrong");
  swing_select_a: assert property ((ce && $stable(pins_b))[*8] |->
    cfg_b.swing == pins_b.swing_sel) else $error("swing of channel B wrong");
  probe_standby_a: assert property (probe_active != 2'h0 |->
    standby && driver_en == 2'h0)
    else $error("outputs live during detection");
  squelch_gate_a: assert property (standby |->
    out_active == 2'h0 && driver_en == 2'h0)
    else $error("output active in standby");
  idle_gate_a: assert property ((ce && $stable(driver_en) &&
    $stable(above_idle_threshold))[*6] |->
    out_active == (driver_en & above_idle_threshold))
    else $error("output does not follow the idle detector");
  shutdown_clear_a: assert property ((!enable && ce)[*6] |->
    detected == 2'h0 && probe_active == 2'h0)
    else $error("detection alive in shutdown");
  driver_found_a: assert property (driver_en != 2'h0 |->
    idle_detect_en == driver_en && (detected & driver_en) == driver_en)
    else $error("driver enabled without receiver");
  give_up_a: assert property ($rose(|detected) && detected != 2'h3 |->
    ##[1:60] (probe_active == 2'h0 || !ce))
    else $error("probing continues past the try limit");
endmodule

bind redriver_lane_control lane_control_checker chk_u (.clk(clk),
  .rst_n(rst_n), .ce(ce), .enable(enable),
  .above_idle_threshold(above_idle_threshold), .pins_a(pins_a),
  .pins_b(pins_b), .cfg_a(cfg_a), .cfg_b(cfg_b),
  .probe_active(probe_active), .standby(standby), .driver_en(driver_en),
  .idle_detect_en(idle_detect_en), .out_active(out_active),
  .detected(detected));

`default_nettype wire

// >>> link_partner_model.sv
`timescale 1ns/1ps
`default_nettype none

// Far-side receivers; a slow one lets lag minus one attempts pass unanswered.
module link_partner_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] present,
  input wire logic [1:0] lag,
  input wire logic [1:0] probe_active,
  input wire logic probe_strobe,
  output logic [1:0] probe_found
);
  logic [1:0] tries;
  logic gap;

  // A long gap between probes means a fresh sequence, so the count restarts.
  always_ff @(posedge clk) begin
    gap <= probe_active == 2'h0;
    if (!rst_n || (gap && probe_active == 2'h0)) begin
      tries <= 2'h0;
    end else if (probe_strobe && tries != 2'h3) begin
      tries <= tries + 2'h1;
    end
    probe_found <= rst_n ? present & probe_active & {2{tries >= lag}} : 2'h0;
  end
endmodule

`default_nettype wire

// >>> pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser; the output only moves when stages two and
// three agree, so a metastable first stage never reaches the logic.
module pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic pin,
  output logic level
);

  logic [2:0] stage;
  wire agree = (stage[1] == stage[2]);

  // Shift the pin through the stages.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage <= redriver_pkg::sync_reset;
    end else if (ce) begin
      stage <= {stage[1], stage[0], pin};
    end
  end

  // Accept a new level only once the later stages agree.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level <= 1'b0;
    end else if (ce && agree) begin
      level <= stage[2];
    end
  end

endmodule

`default_nettype wire

// >>> redriver_lane_control.sv
`timescale 1ns/1ps
`default_nettype none

// Control for a two-channel redriver: setting decode, receiver detection
// sequencing and output gating. Channel index 0 is A, 1 is B.
module redriver_lane_control (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic enable,
  input wire logic rx_probe_trigger,
  input wire redriver_pkg::chan_pins_type pins_a,
  input wire redriver_pkg::chan_pins_type pins_b,
  input wire logic [1:0] probe_found,
  input wire logic [1:0] above_idle_threshold,
  output redriver_pkg::chan_cfg_type cfg_a,
  output redriver_pkg::chan_cfg_type cfg_b,
  output logic [1:0] probe_active,
  output logic probe_strobe,
  output logic standby,
  output logic [1:0] driver_en,
  output logic [1:0] idle_detect_en,
  output logic [1:0] out_active,
  output logic [1:0] detected
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************

  logic en_s;
  logic trig_s;
  logic [1:0] found_s;
  logic [1:0] above_s;
  logic trig_prev;

  // pins are pulled low off chip; reset reads them as low too.
  pin_sync u_sync_en (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pin(enable),
    .level(en_s)
  );

  // trigger synchronised before its edge is compared.
  pin_sync u_sync_trig (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pin(rx_probe_trigger),
    .level(trig_s)
  );

  pin_sync u_sync_found0 (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pin(probe_found[0]),
    .level(found_s[0])
  );

  pin_sync u_sync_found1 (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pin(probe_found[1]),
    .level(found_s[1])
  );

  pin_sync u_sync_above0 (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pin(above_idle_threshold[0]),
    .level(above_s[0])
  );

  pin_sync u_sync_above1 (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pin(above_idle_threshold[1]),
    .level(above_s[1])
  );

  // ****************************************************************
  // Strap pin synchronisation
  // ****************************************************************

  // Strap selects are asynchronous pins too. Each bit has its own
  // synchroniser, so a pair that changes together can decode to a mixed
  // code for a cycle; straps are static in use, so that cost is accepted.
  localparam int strap_bits = $bits(redriver_pkg::chan_pins_type);
  wire redriver_pkg::chan_pins_type pins_a_s;
  wire redriver_pkg::chan_pins_type pins_b_s;

  for (genvar i = 0; i < strap_bits; i++) begin : g_strap
    pin_sync u_sync_a (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .pin(pins_a[i]),
      .level(pins_a_s[i])
    );
    pin_sync u_sync_b (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .pin(pins_b[i]),
      .level(pins_b_s[i])
    );
  end

  // ****************************************************************
  // Setting decode
  // ****************************************************************

  // each channel decodes its own swing and settings.
  chan_cfg_decode u_cfg_a (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pins(pins_a_s),
    .cfg(cfg_a)
  );

  chan_cfg_decode u_cfg_b (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pins(pins_b_s),
    .cfg(cfg_b)
  );

  // ****************************************************************
  // Detection sequencer
  // ****************************************************************

  // A sequence alternates probe and wait until both channels are found,
  // or until the retry budget for the second channel runs out. Trigger
  // edges inside a sequence are not queued: the sequence already covers
  // every channel that has not answered, so a second start would only
  // restart the wait for the same receivers.

  redriver_pkg::det_state_type state;
  redriver_pkg::det_state_type next_state;
  logic [3:0] cnt;
  logic [1:0] tries;
  logic [1:0] next_detected;
  logic [1:0] pending;
  logic power_up;

  // Trigger edge in either direction, seen only while enabled.
  // rising or falling edge counts.
  wire trig_edge = (trig_s != trig_prev);
  // with enable low the trigger is ignored.
  wire start_req = en_s && (trig_edge || power_up);
  wire probe_done = (cnt == redriver_pkg::probe_cycles_w);
  wire [1:0] hits = found_s & pending;
  wire [1:0] new_det = detected | hits;
  // one channel found, the other gets three more tries.
  wire one_found = (new_det != 2'h0) && (new_det != 2'h3);
  wire give_up = one_found && (tries == redriver_pkg::extra_tries);
  wire all_done = (new_det == 2'h3) || give_up;

  // The power-up flag is consumed by the first enabled cycle.
  // power-up with enable high starts detection.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      power_up <= 1'b1;
    end else if (ce && en_s) begin
      power_up <= 1'b0;
    end
  end

  // Remember the previous trigger level for edge compare.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trig_prev <= 1'b0;
    end else if (ce) begin
      trig_prev <= trig_s;
    end
  end

  // Next-state logic; probe and wait alternate until done.
  always_comb begin
    next_state = state;
    case (state)
      redriver_pkg::st_off: begin
        if (start_req) begin
          next_state = redriver_pkg::st_probe;
        end
      end
      redriver_pkg::st_probe: begin
        if (probe_done) begin
          next_state = redriver_pkg::st_wait;
        end
      end
      // retry until every pending channel is found, or until one is and the other has had three more tries.
      redriver_pkg::st_wait: begin
        if (all_done) begin
          next_state = redriver_pkg::st_run;
        end else begin
          next_state = redriver_pkg::st_probe;
        end
      end
      redriver_pkg::st_run: begin
        if (trig_edge) begin
          next_state = redriver_pkg::st_probe;
        end
      end
      default: begin
        next_state = redriver_pkg::st_off;
      end
    endcase
    if (!en_s) begin
      next_state = redriver_pkg::st_off;
    end
  end

  // detected flags cleared by enable low or a new start.
  assign next_detected = !en_s ? 2'h0 :
    (state == redriver_pkg::st_wait) ? new_det :
    ((state != redriver_pkg::st_probe) && (next_state ==
      redriver_pkg::st_probe)) ? 2'h0 : detected;

  // State, detected flags and retry counter.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= redriver_pkg::st_off;
      detected <= 2'h0;
      tries <= redriver_pkg::tries_reset;
    end else if (ce) begin
      state <= next_state;
      detected <= next_detected;
      if (next_state != redriver_pkg::st_wait &&
          state != redriver_pkg::st_wait) begin
        tries <= tries;
      end else if (state == redriver_pkg::st_wait && one_found) begin
        tries <= tries + 2'h1;
      end
      if (next_state == redriver_pkg::st_off ||
          (state != redriver_pkg::st_probe &&
           state != redriver_pkg::st_wait &&
           next_state == redriver_pkg::st_probe)) begin
        tries <= redriver_pkg::tries_reset;
      end
    end
  end

  // Probe-interval counter, restarted every attempt.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= redriver_pkg::cnt_reset;
    end else if (ce) begin
      if (state == redriver_pkg::st_probe && !probe_done) begin
        cnt <= cnt + 4'h1;
      end else begin
        cnt <= redriver_pkg::cnt_reset;
      end
    end
  end

  // Channels still waiting for a receiver during this sequence.
  assign pending = ~detected;

  // ****************************************************************
  // Output gating
  // ****************************************************************

  // Gating follows the state being entered, so the outputs drop at the
  // same edge that leaves run; a one-cycle lag would leave a driver on
  // while detection has already restarted or enable has gone low.
  wire enter_run = (next_state == redriver_pkg::st_run);
  wire [1:0] next_live = enter_run ? next_detected : 2'h0;

  // Probe requests are combinational handshake outputs.
  assign probe_active = (state == redriver_pkg::st_probe) ? pending : 2'h0;
  assign probe_strobe = (state == redriver_pkg::st_probe) && (cnt == 4'h0);

  // standby and squelch while detection runs or when disabled.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      standby <= 1'b1;
      driver_en <= 2'h0;
      idle_detect_en <= 2'h0;
      out_active <= 2'h0;
    end else if (ce) begin
      standby <= !enter_run;
      // a detected channel gets driver and idle detection.
      driver_en <= next_live;
      idle_detect_en <= next_live;
      out_active <= next_live & above_s;
    end
  end

endmodule

`default_nettype wire

// >>> redriver_lane_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module redriver_lane_control_tb;
  logic clk, rst_n, ce, enable, trig, strobe, standby;
  redriver_pkg::chan_pins_type pins_a, pins_b;
  redriver_pkg::chan_cfg_type cfg_a, cfg_b;
  logic [1:0] found, idle, active, den, iden, oact, det, present, lag, c, lv;
  int bad_count, num_checks, n;

  redriver_lane_control dut_u (.clk(clk), .rst_n(rst_n), .ce(ce),
    .enable(enable), .rx_probe_trigger(trig), .pins_a(pins_a),
    .pins_b(pins_b), .probe_found(found), .above_idle_threshold(idle),
    .cfg_a(cfg_a), .cfg_b(cfg_b), .probe_active(active),
    .probe_strobe(strobe), .standby(standby), .driver_en(den),
    .idle_detect_en(iden), .out_active(oact), .detected(det));
  link_partner_model peer_u (.clk(clk), .rst_n(rst_n), .present(present),
    .lag(lag), .probe_active(active), .probe_strobe(strobe),
    .probe_found(found));

  // Free-running 10 MHz clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Inputs move 10 ns after the edge, clear of the sampling instant.
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #10;
  endtask

  task automatic chk(input string what, input logic [4:0] exp,
                     input logic [4:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Bounded wait for the driver enables; a timeout ends the run.
  task automatic wait_den(input logic [1:0] exp);
    n = 0;
    while (den !== exp && n < 300) begin
      step(1);
      n++;
    end
    chk("driver_en", {3'h0, exp}, {3'h0, den});
    if (den !== exp) test_done();
  endtask

  // Samples the strobe once per cycle, where it stands for one cycle.
  task automatic count_strobes(input int k);
    n = 0;
    repeat (k) begin
      step(1);
      if (strobe === 1'b1) n++;
    end
  endtask

  // Main sequence; enable is high during reset to model power-up.
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    enable = 1'b1;
    trig = 1'b0;
    pins_a = '0;
    pins_b = '0;
    idle = 2'h0;
    present = 2'h3;
    lag = 2'h0;
    bad_count = 0;
    num_checks = 0;
    step(16);
    rst_n = 1'b1;
    step(8);
    chk("probe_active", 5'h3, {3'h0, active});
    chk("standby", 5'h1, {4'h0, standby});
    wait_den(2'h3);
    chk("idle_detect_en", 5'h3, {3'h0, iden});
    idle = 2'h1;
    step(6);
    chk("out_active", 5'h1, {3'h0, oact});
    idle = 2'h2;
    step(6);
    chk("out_active", 5'h2, {3'h0, oact});
    // Each select code of each channel, the two channels kept different.
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      pins_a = {c, c, c[0]};
      pins_b = {~c, ~c, ~c[0]};
      step(8);
      lv = c[1] ? 2'h2 : {1'b0, c[0]};
      chk("cfg_a", {lv, lv, c[0]}, cfg_a);
      lv = ~c[1] ? 2'h2 : {1'b0, ~c[0]};
      chk("cfg_b", {lv, lv, ~c[0]}, cfg_b);
    end
    enable = 1'b0;
    step(8);
    chk("detected", 5'h0, {3'h0, det});
    chk("standby", 5'h1, {4'h0, standby});
    trig = 1'b1;
    count_strobes(30);
    chk("strobes", 5'h0, 5'(n));
    present = 2'h1;
    enable = 1'b1;
    step(10);
    trig = 1'b0;
    count_strobes(90);
    chk("strobes", 5'h1, {4'h0, n >= 1 && n <= 4});
    chk("driver_en", 5'h1, {3'h0, den});
    present = 2'h0;
    trig = 1'b1;
    count_strobes(100);
    chk("strobes", 5'h1, {4'h0, n >= 6});
    chk("driver_en", 5'h0, {3'h0, den});
    enable = 1'b0;
    step(8);
    lag = 2'h2;
    present = 2'h2;
    enable = 1'b1;
    step(10);
    trig = 1'b0;
    wait_den(2'h2);
    chk("idle_detect_en", 5'h2, {3'h0, iden});
    test_done();
  end
endmodule

`default_nettype wire

// >>> redriver_pkg.sv
// Overview of operation
// - Boost select: 00 gives none, 01 gives 3.5 dB, 1x gives 6 dB.
// - De-emphasis select: 00 gives none, 01 gives 3.5 dB, 1x gives 6 dB.
// - Power-up with enable high starts receiver detection with no trigger edge.
// - With enable high, either edge of the trigger starts detection.
// - During detection the part stays in standby with both outputs squelched.
// - Detection retries on both channels without limit until one channel finds a receiver.
// - After one channel detects, at most three more tries on the other.
// - A detected channel gets its driver and idle detection enabled.
// - Enable low means shutdown; detection is inactive and trigger is ignored.
// - An enabled channel squelches below the idle threshold, drives above it.
// - Each channel has its own swing select, applied independently.
// - Swing select 0 gives 1000 mV nominal, 1 gives reduced 750 mV.
// - Undriven enable and selects read low, giving standby and lowest settings.
`default_nettype none

package redriver_pkg;

  // ****************************************************************
  // Encodings
  // ****************************************************************

  // Gain level shared by equaliser boost and de-emphasis.
  typedef enum logic [1:0] {
    level_0db = 2'h0,
    level_3p5db = 2'h1,
    level_6db = 2'h2
  } level_type;

  // Output swing level.
  typedef enum logic {
    swing_1000mv = 1'h0,
    swing_750mv = 1'h1
  } swing_type;

  // Detection sequencer states.
  typedef enum logic [1:0] {
    st_off = 2'h0,
    st_probe = 2'h1,
    st_wait = 2'h2,
    st_run = 2'h3
  } det_state_type;

  // ****************************************************************
  // Carriers
  // ****************************************************************

  // Static pin settings of one channel.
  typedef struct packed {
    logic boost_sel_hi;
    logic boost_sel_lo;
    logic deemph_sel_hi;
    logic deemph_sel_lo;
    logic swing_sel;
  } chan_pins_type;

  // Decoded settings of one channel.
  typedef struct packed {
    level_type boost;
    level_type deemph;
    swing_type swing;
  } chan_cfg_type;

  // ****************************************************************
  // Constants
  // ****************************************************************

  localparam int clk_mhz = 10;
  localparam int probe_time_ns = 1000;
  localparam int probe_cycles = (probe_time_ns * clk_mhz + 999) / 1000;
  localparam logic [3:0] probe_cycles_w = 4'(probe_cycles);
  localparam logic [1:0] extra_tries = 2'h3;
  localparam logic [3:0] cnt_reset = 4'h0;
  localparam logic [1:0] tries_reset = 2'h0;
  localparam logic [2:0] sync_reset = 3'h0;

  // Shared decode of a two-bit select pair.
  function automatic level_type decode_level(input logic hi,
                                             input logic lo);
    if (hi) begin
      return level_6db;
    end
    return lo ? level_3p5db : level_0db;
  endfunction

endpackage

`default_nettype wire
